/* File: hw/l2dl_pkg.sv */
/*
 Constants, table layouts and table selectors for the layer-2
 destination lookup.
 Assumes one clock domain and no register bus.
*/
// Behaviour
// RQ1: hash group plus destination, read four buckets
// RQ2: bucket equal to full key is a hit
// RQ3: CAM scan from entry 0, lowest wins
// RQ4: mask zero ignores that key bit
// RQ5: hit needs every aging valid bit set
// RQ6: CAM hit overrides hashed hit
// RQ7: CAM results stored after hashed results
// RQ8: entry drop flag drops the packet
// RQ9: single-port flag forwards to target port
// RQ10: otherwise target indexes multicast portmask
// RQ11: all-ones destination goes to VLAN members
// RQ12: remove ingress port; empty means counted drop
// RQ13: hairpin keeps the ingress port
// RQ14: prune non-members; empty means counted drop
// RQ15: no hit floods to VLAN members
// RQ16: flood redirect sends to one configured port
// RQ17: hit sets the aging hit bit
// RQ18: software updates tables only by safe method
// RQ19: per-port action tables, four shared special rules; the code keeps one egress action table shared by all ports
// RQ20: empty mask skips egress actions, source applies
// RQ21: source multicast picks group no-learn flag
// RQ22: action drop still learns unless suppressed
// RQ23: special drop, move drop, drop-all, one CPU copy
package l2dl_pkg;
    localparam int NPORT = 11;
    localparam int PW = 4;
    localparam int GID_W = 12;
    localparam int MAC_W = 48;
    localparam int KEY_W = GID_W + MAC_W;
    localparam int ROW_W = 10;
    localparam int WAYS = 4;
    localparam int HASH_N = 4096;
    localparam int HASH_AW = 12;
    localparam int CAM_N = 32;
    localparam int CAM_AW = 5;
    localparam int CAM_MSK_N = 4;
    localparam int DEST_N = HASH_N + CAM_N;
    localparam int DEST_AW = 13;
    localparam int MC_N = 64;
    localparam int MC_AW = 6;
    localparam int RULE_N = 4;
    localparam int CLS_W = 4;
    localparam int ACT_N = 16;
    localparam int WR_W = 64;
    // destination entry layout
    localparam int DST_W = 8;
    localparam int DST_DROP_BIT = 7;
    localparam int DST_UC_BIT = 6;
    localparam int DST_FLD_W = 6;
    // action entry layout
    localparam int ACT_W = 8;
    localparam int ACT_DROP_ALL = 0;
    localparam int ACT_NL_MC = 1;
    localparam int ACT_NL_UC = 2;
    localparam int ACT_TO_CPU = 3;
    localparam int ACT_MOVE_DROP = 4;
    localparam int ACT_SPEC_USE = 5;
    localparam int ACT_SPEC_LSB = 6;
    // aging valid bits: table, shadow, replica
    localparam int AGE_W = 3;
    localparam int CAM_AGE_W = 2;
    localparam int SA_GROUP_BIT = 40;
    localparam logic [MAC_W-1:0] BCAST_MAC = 48'hFFFFFFFFFFFF;
    localparam logic [31:0] DROP_CNT_RST = 32'h00000000;
    localparam int LOOKUP_LAT = 2;

    typedef enum logic [3:0] {
        TBL_HASH, TBL_AGE, TBL_CAM, TBL_CAM_MASK, TBL_CAM_AGE,
        TBL_DEST, TBL_MCAST, TBL_SRC_ACT, TBL_EGR_ACT, TBL_RULE,
        TBL_HIT_CLR
    } l2dl_tbl_t;
endpackage : l2dl_pkg

/* File: hw/l2dl_hash.sv */
/*
 Folds the group plus destination key into a bucket row.
 Assumes a registered key from the lookup stage.
*/
`timescale 1ns/1ps
module l2dl_hash (
    // key in
    input wire logic [l2dl_pkg::KEY_W-1:0] key,
    // row out
    output logic [l2dl_pkg::ROW_W-1:0] row
);
    always_comb begin
        row = '0;
        for (int i = 0; i < l2dl_pkg::KEY_W; i++) begin
            row[i % l2dl_pkg::ROW_W] = row[i % l2dl_pkg::ROW_W] ^ key[i];
        end
    end
endmodule : l2dl_hash

/* File: hw/l2dl_cam.sv */
/*
 Collision CAM compare with per-bit masks and lowest-index priority.
 Assumes masks of unmaskable entries are tied to all ones.
*/
`timescale 1ns/1ps
module l2dl_cam (
    // clock for checks
    input wire logic sys_clk,
    input wire logic nrst,
    // key and entries
    input wire logic [l2dl_pkg::KEY_W-1:0] key,
    input wire logic [l2dl_pkg::KEY_W-1:0] ent_key [l2dl_pkg::CAM_N],
    input wire logic [l2dl_pkg::KEY_W-1:0] ent_mask [l2dl_pkg::CAM_N],
    input wire logic [l2dl_pkg::CAM_N-1:0] ent_vld,
    // result
    output logic hit,
    output logic [l2dl_pkg::CAM_AW-1:0] idx
);
    logic [l2dl_pkg::CAM_N-1:0] match;

    genvar g;
    generate
        for (g = 0; g < l2dl_pkg::CAM_N; g++) begin : g_ent
            assign match[g] = ent_vld[g] &&             // [RQ5]
                (((key ^ ent_key[g]) & ent_mask[g]) == '0); // [RQ4]
        end
    endgenerate

    always_comb begin
        hit = |match;
        idx = '0;
        for (int i = l2dl_pkg::CAM_N - 1; i >= 0; i--) begin
            if (match[i]) begin
                idx = l2dl_pkg::CAM_AW'(i); // [RQ3]
            end
        end
    end

    AST_CAM_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
        hit |-> (match & ((32'h00000001 << idx) - 32'h00000001)) == '0
    ) else $error("cam took a later match"); // [RQ3]
endmodule : l2dl_cam

/* File: hw/l2dl_lookup.sv */
/*
 Layer-2 destination lookup: hashed table, collision CAM, destination
 and multicast tables, port pruning, action tables, hit bits.
 Assumes request fields and per-port settings come from clocked logic
 on sys_clk; tables are written through the plain write port.
*/
`timescale 1ns/1ps
module l2dl_lookup (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // lookup request
    input wire logic req_valid,
    input wire logic [l2dl_pkg::GID_W-1:0] req_gid,
    input wire logic [l2dl_pkg::MAC_W-1:0] req_da,
    input wire logic [l2dl_pkg::MAC_W-1:0] req_sa,
    input wire logic [l2dl_pkg::PW-1:0] req_src_port,
    input wire logic [l2dl_pkg::NPORT-1:0] vlan_member_mask,
    input wire logic req_hairpin_en,
    input wire logic req_redir_en,
    input wire logic [l2dl_pkg::PW-1:0] req_redir_port,
    input wire logic action_table_use,
    input wire logic req_src_state,
    input wire logic req_sa_known,
    input wire logic req_port_move,
    input wire logic [l2dl_pkg::CLS_W-1:0] req_frame_class,
    // egress port states
    input wire logic [l2dl_pkg::NPORT-1:0] egress_state,
    // table write
    input wire logic tbl_wr_en,
    input wire l2dl_pkg::l2dl_tbl_t tbl_wr_sel,
    input wire logic [l2dl_pkg::DEST_AW-1:0] tbl_wr_addr,
    input wire logic [l2dl_pkg::WR_W-1:0] tbl_wr_data,
    // lookup result
    output logic res_valid,
    output logic [l2dl_pkg::NPORT-1:0] res_portmask,
    output logic res_drop,
    output logic res_to_cpu,
    output logic res_learn,
    output logic res_hit,
    output logic res_cam_hit,
    // status
    output logic [31:0] lookup_drop_cnt,
    input wire logic [l2dl_pkg::DEST_AW-1:0] hit_rd_addr,
    output logic hit_rd_data
);
    localparam int KW = l2dl_pkg::KEY_W;
    localparam int NP = l2dl_pkg::NPORT;

    // tables
    logic [KW-1:0] hash_key_mem [l2dl_pkg::HASH_N];
    logic [l2dl_pkg::AGE_W-1:0] age_vld_ff [l2dl_pkg::HASH_N];
    logic [KW-1:0] cam_key_mem [l2dl_pkg::CAM_N];
    logic [KW-1:0] cam_mask_mem [l2dl_pkg::CAM_MSK_N];
    logic [l2dl_pkg::CAM_AGE_W-1:0] cam_vld_ff [l2dl_pkg::CAM_N];
    logic [l2dl_pkg::DST_W-1:0] dest_mem [l2dl_pkg::DEST_N];
    logic [NP-1:0] mc_mem [l2dl_pkg::MC_N];
    logic [l2dl_pkg::ACT_W-1:0] src_act_mem [l2dl_pkg::ACT_N];
    logic [l2dl_pkg::ACT_W-1:0] egr_act_mem [l2dl_pkg::ACT_N];
    logic [l2dl_pkg::CLS_W-1:0] rule_mem [l2dl_pkg::RULE_N];
    logic hit_bit_ff [l2dl_pkg::DEST_N];

    // first stage request
    logic v1_ff;
    logic [KW-1:0] key_ff;
    logic [l2dl_pkg::MAC_W-1:0] sa_ff;
    logic [l2dl_pkg::PW-1:0] src_ff;
    logic [NP-1:0] vlan_ff;
    logic hp_ff;
    logic redir_en_ff;
    logic [l2dl_pkg::PW-1:0] redir_port_ff;
    logic act_use_ff;
    logic src_state_ff;
    logic sa_known_ff;
    logic move_ff;
    logic [l2dl_pkg::CLS_W-1:0] cls_ff;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            v1_ff <= 1'b0;
        end else begin
            v1_ff <= req_valid;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (req_valid) begin
            key_ff <= {req_gid, req_da}; // [RQ1]
            sa_ff <= req_sa;
            src_ff <= req_src_port;
            vlan_ff <= vlan_member_mask;
            hp_ff <= req_hairpin_en;
            redir_en_ff <= req_redir_en;
            redir_port_ff <= req_redir_port;
            act_use_ff <= action_table_use;
            src_state_ff <= req_src_state;
            sa_known_ff <= req_sa_known;
            move_ff <= req_port_move;
            cls_ff <= req_frame_class;
        end
    end

    // table writes; valid bits cleared at reset
    always_ff @(posedge sys_clk) begin
        if (tbl_wr_en) begin
            unique case (tbl_wr_sel)
                l2dl_pkg::TBL_HASH: hash_key_mem[tbl_wr_addr[11:0]] <=
                    tbl_wr_data[KW-1:0];
                l2dl_pkg::TBL_CAM: cam_key_mem[tbl_wr_addr[4:0]] <=
                    tbl_wr_data[KW-1:0];
                l2dl_pkg::TBL_CAM_MASK: cam_mask_mem[tbl_wr_addr[1:0]] <=
                    tbl_wr_data[KW-1:0];
                l2dl_pkg::TBL_DEST: dest_mem[tbl_wr_addr] <=
                    tbl_wr_data[l2dl_pkg::DST_W-1:0];
                l2dl_pkg::TBL_MCAST: mc_mem[tbl_wr_addr[5:0]] <=
                    tbl_wr_data[NP-1:0];
                l2dl_pkg::TBL_SRC_ACT: src_act_mem[tbl_wr_addr[3:0]] <=
                    tbl_wr_data[l2dl_pkg::ACT_W-1:0];
                l2dl_pkg::TBL_EGR_ACT: egr_act_mem[tbl_wr_addr[3:0]] <=
                    tbl_wr_data[l2dl_pkg::ACT_W-1:0];
                l2dl_pkg::TBL_RULE: rule_mem[tbl_wr_addr[1:0]] <=
                    tbl_wr_data[l2dl_pkg::CLS_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < l2dl_pkg::HASH_N; i++) begin
                age_vld_ff[i] <= '0;
            end
            for (int i = 0; i < l2dl_pkg::CAM_N; i++) begin
                cam_vld_ff[i] <= '0;
            end
        end else if (tbl_wr_en && tbl_wr_sel == l2dl_pkg::TBL_AGE) begin
            age_vld_ff[tbl_wr_addr[11:0]] <=
                tbl_wr_data[l2dl_pkg::AGE_W-1:0];
        end else if (tbl_wr_en && tbl_wr_sel == l2dl_pkg::TBL_CAM_AGE) begin
            cam_vld_ff[tbl_wr_addr[4:0]] <=
                tbl_wr_data[l2dl_pkg::CAM_AGE_W-1:0];
        end
    end

    // hashed lookup
    logic [l2dl_pkg::ROW_W-1:0] row;
    logic [l2dl_pkg::WAYS-1:0] bhit;
    logic [1:0] way;

    l2dl_hash u_hash (
        .key(key_ff),
        .row(row)
    );

    genvar g;
    generate
        for (g = 0; g < l2dl_pkg::WAYS; g++) begin : g_way
            assign bhit[g] = (&age_vld_ff[{row, 2'(g)}]) && // [RQ5]
                (hash_key_mem[{row, 2'(g)}] == key_ff); // [RQ1] [RQ2]
        end
    endgenerate

    always_comb begin
        way = 2'h0;
        for (int i = l2dl_pkg::WAYS - 1; i >= 0; i--) begin
            if (bhit[i]) begin
                way = 2'(i);
            end
        end
    end

    // collision CAM
    logic [KW-1:0] cam_mask [l2dl_pkg::CAM_N];
    logic [l2dl_pkg::CAM_N-1:0] cam_vld;
    logic cam_hit;
    logic [l2dl_pkg::CAM_AW-1:0] cam_idx;

    generate
        for (g = 0; g < l2dl_pkg::CAM_N; g++) begin : g_cam
            assign cam_vld[g] = &cam_vld_ff[g]; // [RQ5]
            if (g < l2dl_pkg::CAM_MSK_N) begin : g_msk
                assign cam_mask[g] = cam_mask_mem[g]; // [RQ4]
            end else begin : g_full
                assign cam_mask[g] = '1;
            end
        end
    endgenerate

    l2dl_cam u_cam (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .key(key_ff),
        .ent_key(cam_key_mem),
        .ent_mask(cam_mask),
        .ent_vld(cam_vld),
        .hit(cam_hit),
        .idx(cam_idx)
    );

    // destination resolution
    logic hit;
    logic [l2dl_pkg::DEST_AW-1:0] hit_idx;
    logic [l2dl_pkg::DST_W-1:0] dest;
    logic [l2dl_pkg::DST_FLD_W-1:0] fld;
    logic bcast;
    logic flood;
    logic redir;
    logic entry_drop;
    logic [NP-1:0] src_oh;
    logic [NP-1:0] redir_oh;
    logic [NP-1:0] uc_oh;
    logic [NP-1:0] base;
    logic [NP-1:0] excl;
    logic [NP-1:0] pruned;
    logic empty_drop;

    assign hit = cam_hit || (|bhit);
    assign hit_idx = cam_hit ?
        l2dl_pkg::DEST_AW'(l2dl_pkg::HASH_N) + {8'h00, cam_idx} // [RQ6] [RQ7]
        : {1'b0, row, way};
    assign dest = dest_mem[hit_idx];
    assign fld = dest[l2dl_pkg::DST_FLD_W-1:0];
    assign bcast = key_ff[l2dl_pkg::MAC_W-1:0] == l2dl_pkg::BCAST_MAC;
    assign flood = !hit; // [RQ15]
    assign redir = flood && !bcast && redir_en_ff; // [RQ16]
    assign entry_drop = hit && dest[l2dl_pkg::DST_DROP_BIT]; // [RQ8]

    generate
        for (g = 0; g < NP; g++) begin : g_oh
            assign src_oh[g] = src_ff == l2dl_pkg::PW'(g);
            assign redir_oh[g] = redir_port_ff == l2dl_pkg::PW'(g);
            assign uc_oh[g] = fld == 6'(g); // [RQ9]
        end
    endgenerate

    always_comb begin
        if (redir) begin
            base = redir_oh; // [RQ16]
        end else if (flood || bcast) begin
            base = vlan_ff; // [RQ11] [RQ15]
        end else if (dest[l2dl_pkg::DST_UC_BIT]) begin
            base = uc_oh; // [RQ9]
        end else begin
            base = mc_mem[fld]; // [RQ10]
        end
        excl = hp_ff ? base : (base & ~src_oh); // [RQ12] [RQ13]
        pruned = redir ? excl : (excl & vlan_ff); // [RQ14]
    end

    assign empty_drop = !entry_drop && (pruned == '0); // [RQ12] [RQ14]

    // action tables
    function automatic logic [1:0] spec_eval(
        input logic [l2dl_pkg::ACT_W-1:0] a);
        logic ok;
        ok = |(rule_mem[a[l2dl_pkg::ACT_SPEC_LSB +: 2]] & cls_ff);
        spec_eval = {a[l2dl_pkg::ACT_SPEC_USE] && !ok, // special drop
                     a[l2dl_pkg::ACT_SPEC_USE] && ok}; // [RQ19]
    endfunction : spec_eval

    logic [3:0] src_addr;
    logic [l2dl_pkg::ACT_W-1:0] src_act;
    logic [NP-1:0] e_on;
    logic [l2dl_pkg::ACT_W-1:0] e_act [NP];
    logic [1:0] e_spec [NP];
    logic [l2dl_pkg::ACT_W-1:0] act;
    logic spec_drop;
    logic spec_ok;
    logic act_drop;

    assign src_addr = {src_state_ff, sa_known_ff, hit, pruned == '0};
    assign src_act = act_use_ff ? src_act_mem[src_addr] : '0; // [RQ20]

    generate
        for (g = 0; g < NP; g++) begin : g_egr
            assign e_on[g] = act_use_ff && pruned[g]; // [RQ19] [RQ20]
            assign e_act[g] = e_on[g] ? egr_act_mem[{src_state_ff,
                egress_state[g], sa_known_ff, hit}] : '0;
            assign e_spec[g] = spec_eval(e_act[g]);
        end
    endgenerate

    always_comb begin
        act = src_act;
        {spec_drop, spec_ok} = spec_eval(src_act);
        for (int i = 0; i < NP; i++) begin
            act = act | e_act[i];
            spec_drop = spec_drop | e_spec[i][1];
            spec_ok = spec_ok | e_spec[i][0];
        end
        act_drop = spec_drop // [RQ23]
            || (act[l2dl_pkg::ACT_MOVE_DROP] && move_ff)
            || (act[l2dl_pkg::ACT_DROP_ALL] && !spec_ok);
    end

    // result stage
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            res_valid <= 1'b0;
            res_portmask <= '0;
            res_drop <= 1'b0;
            res_to_cpu <= 1'b0;
            res_learn <= 1'b0;
            res_hit <= 1'b0;
            res_cam_hit <= 1'b0;
        end else begin
            res_valid <= v1_ff;
            res_portmask <= v1_ff ? pruned : '0;
            res_drop <= v1_ff && (entry_drop || empty_drop || act_drop);
            res_to_cpu <= v1_ff && !(entry_drop || empty_drop || act_drop)
                && act[l2dl_pkg::ACT_TO_CPU]; // [RQ23]
            res_learn <= v1_ff && !(sa_ff[l2dl_pkg::SA_GROUP_BIT] ?
                act[l2dl_pkg::ACT_NL_MC] :
                act[l2dl_pkg::ACT_NL_UC]); // [RQ21] [RQ22]
            res_hit <= v1_ff && hit;
            res_cam_hit <= v1_ff && cam_hit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lookup_drop_cnt <= l2dl_pkg::DROP_CNT_RST;
        end else if (v1_ff && empty_drop) begin
            lookup_drop_cnt <= lookup_drop_cnt + 32'h00000001; // [RQ12]
        end
    end

    // hit bits: a set in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < l2dl_pkg::DEST_N; i++) begin
                hit_bit_ff[i] <= 1'b0;
            end
        end else begin
            if (tbl_wr_en && tbl_wr_sel == l2dl_pkg::TBL_HIT_CLR) begin
                hit_bit_ff[tbl_wr_addr] <= 1'b0;
            end
            if (v1_ff && hit) begin
                hit_bit_ff[hit_idx] <= 1'b1; // [RQ17]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            hit_rd_data <= 1'b0;
        end else begin
            hit_rd_data <= hit_bit_ff[hit_rd_addr];
        end
    end

    // checks
    sequence s_take;
        req_valid ##1 v1_ff;
    endsequence

    AST_LATENCY: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_take |=> res_valid
    ) else $error("result not two cycles after request"); // [RQ1]
    AST_CAM_WINS: assert property (@(posedge sys_clk) disable iff (!nrst)
        v1_ff && cam_hit |=> res_cam_hit && res_hit
            && $past(hit_idx) >= 13'h1000
    ) else $error("cam result not preferred"); // [RQ6]
    AST_DROP_ENTRY: assert property (@(posedge sys_clk) disable iff (!nrst)
        v1_ff && hit && dest[l2dl_pkg::DST_DROP_BIT] |=> res_drop
    ) else $error("entry drop flag ignored"); // [RQ8]
    AST_SRC_EXCL: assert property (@(posedge sys_clk) disable iff (!nrst)
        v1_ff && !hp_ff && src_ff < 4'hB |=>
            res_portmask[$past(src_ff)] == 1'b0
    ) else $error("ingress port kept without hairpin"); // [RQ12]
    AST_VLAN_PRUNE: assert property (@(posedge sys_clk) disable iff (!nrst)
        v1_ff && !redir |=> (res_portmask & ~$past(vlan_ff)) == '0
    ) else $error("non-member port in mask"); // [RQ14]
    AST_EMPTY_CNT: assert property (@(posedge sys_clk) disable iff (!nrst)
        v1_ff && empty_drop |=> res_drop
            && lookup_drop_cnt == $past(lookup_drop_cnt) + 32'h00000001
    ) else $error("empty mask not counted"); // [RQ12]
    AST_HIT_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
        v1_ff && hit |=> hit_bit_ff[$past(hit_idx)]
    ) else $error("hit bit not set"); // [RQ17]
    AST_ONE_CPU: assert property (@(posedge sys_clk) disable iff (!nrst)
        res_to_cpu |-> !res_drop && res_valid
    ) else $error("cpu copy on dropped packet"); // [RQ23]
    AST_FLOOD: assert property (@(posedge sys_clk) disable iff (!nrst)
        v1_ff && !hit && !redir_en_ff |=> res_portmask ==
            ($past(vlan_ff) & ~($past(src_oh) & {NP{!$past(hp_ff)}}))
    ) else $error("miss not flooded to members"); // [RQ15]
endmodule : l2dl_lookup

/* File: sim/l2dl_cfg_model.sv */
/*
 Table writer standing in for configuration software.
 Assumes lookups come from the bench on sys_clk; writes wait for
 an idle lookup path.
*/
`timescale 1ns/1ps
module l2dl_cfg_model (
    // clock and lookup activity
    input wire logic sys_clk,
    input wire logic req_valid,
    // table write
    output logic tbl_wr_en,
    output l2dl_pkg::l2dl_tbl_t tbl_wr_sel,
    output logic [12:0] tbl_wr_addr,
    output logic [63:0] tbl_wr_data
);
    logic [1:0] inflight_ff = 2'h0;
    initial begin
        tbl_wr_en = 1'b0;
        tbl_wr_sel = l2dl_pkg::TBL_HASH;
        tbl_wr_addr = 13'h0000;
        tbl_wr_data = 64'h0;
    end
    always @(posedge sys_clk) inflight_ff <= {inflight_ff[0], req_valid};
    task automatic wr(input l2dl_pkg::l2dl_tbl_t s, input logic [12:0] a,
                      input logic [63:0] d);
        // no table change while a lookup is in flight
        do @(posedge sys_clk); while (req_valid || inflight_ff != 2'h0);
        tbl_wr_en <= 1'b1;
        tbl_wr_sel <= s;
        tbl_wr_addr <= a;
        tbl_wr_data <= d;
        @(posedge sys_clk);
        tbl_wr_en <= 1'b0;
    endtask : wr
endmodule : l2dl_cfg_model

/* File: sim/testbench.sv */
/*
 Self-checking bench for the destination lookup.
 Assumes the lookup answers two cycles after each request.
*/
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0;
    logic [11:0] req_gid = 12'h000;
    logic [47:0] req_da = 48'h0, req_sa = 48'h0, sa_v;
    logic [3:0] req_src_port = 4'h0, req_redir_port = 4'h0;
    logic [3:0] req_frame_class = 4'h0, fc_v = 4'h0;
    logic [10:0] vlan_member_mask = 11'h000, egress_state = 11'h000;
    logic req_hairpin_en = 1'b0, req_redir_en = 1'b0;
    logic action_table_use = 1'b0, req_port_move = 1'b0;
    logic tbl_wr_en, res_valid, res_drop, res_to_cpu, res_learn;
    logic res_hit, res_cam_hit, hit_rd_data;
    l2dl_pkg::l2dl_tbl_t tbl_wr_sel;
    logic [12:0] tbl_wr_addr, hit_rd_addr = 13'h0000;
    logic [63:0] tbl_wr_data;
    logic [10:0] res_portmask;
    logic [31:0] lookup_drop_cnt, rg;
    logic [15:0] exp_q[$];
    logic [15:0] ev;
    int error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'h41DBBFAA;
    always #25 sys_clk = ~sys_clk;
    l2dl_cfg_model cfg_i (.sys_clk(sys_clk), .req_valid(req_valid),
        .tbl_wr_en(tbl_wr_en), .tbl_wr_sel(tbl_wr_sel),
        .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data));
    l2dl_lookup l2dl_lookup_i (.sys_clk(sys_clk), .nrst(nrst),
        .req_valid(req_valid), .req_gid(req_gid), .req_da(req_da),
        .req_sa(req_sa), .req_src_port(req_src_port),
        .vlan_member_mask(vlan_member_mask),
        .req_hairpin_en(req_hairpin_en), .req_redir_en(req_redir_en),
        .req_redir_port(req_redir_port),
        .action_table_use(action_table_use), .req_src_state(1'b0),
        .req_sa_known(1'b0), .req_port_move(req_port_move),
        .req_frame_class(req_frame_class), .egress_state(egress_state),
        .tbl_wr_en(tbl_wr_en), .tbl_wr_sel(tbl_wr_sel),
        .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data),
        .res_valid(res_valid), .res_portmask(res_portmask),
        .res_drop(res_drop), .res_to_cpu(res_to_cpu),
        .res_learn(res_learn), .res_hit(res_hit),
        .res_cam_hit(res_cam_hit), .lookup_drop_cnt(lookup_drop_cnt),
        .hit_rd_addr(hit_rd_addr), .hit_rd_data(hit_rd_data));

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    function automatic logic [9:0] hrow(input logic [59:0] k);
        hrow = 10'h000;
        for (int i = 0; i < 60; i++) hrow[i % 10] ^= k[i];
    endfunction : hrow
    function automatic logic [15:0] ex(input logic c, dr, h, l, cp,
                                       input logic [10:0] m);
        return {c, dr, h, l, cp, m};
    endfunction : ex
    // hashed entry with full aging valid and a destination
    task automatic put(input logic [11:0] g, input logic [47:0] d,
                       input logic [1:0] w, input logic [7:0] dst);
        logic [12:0] ix;
        ix = {1'b0, hrow({g, d}), w};
        cfg_i.wr(l2dl_pkg::TBL_HASH, ix, {4'h0, g, d});
        cfg_i.wr(l2dl_pkg::TBL_AGE, ix, 64'h7);
        cfg_i.wr(l2dl_pkg::TBL_DEST, ix, {56'h0, dst});
    endtask : put
    task automatic look(input logic [11:0] g, input logic [47:0] d,
                        input logic [3:0] s, input logic [10:0] v,
                        input logic [15:0] e);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_gid <= g;
        req_da <= d;
        req_sa <= sa_v;
        req_src_port <= s;
        vlan_member_mask <= v;
        req_frame_class <= fc_v;
        egress_state <= 11'($random(seed));
        exp_q.push_back(e);
    endtask : look
    task automatic idle(input int n);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask : idle
    task automatic miss(input logic [3:0] s, input logic [10:0] v,
                        input logic [15:0] e);
        rg = $random(seed);
        look(rg[11:0] | 12'h800, {16'h0200, 32'($random(seed))}, s, v, e);
    endtask : miss

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc >= 4000) begin
            error_cnt++;
            conclude();
        end
        if (res_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("extra result", 1, 0);
            else begin
                ev = exp_q.pop_front();
                if (ev[15]) chk("portmask", res_portmask, ev[10:0]);
                chk("drop", res_drop, ev[14]);
                chk("hit", res_hit, ev[13]);
                chk("learn", res_learn, ev[12]);
                chk("cpu", res_to_cpu, ev[11]);
            end
        end
    end

    initial begin
        sa_v = {16'h0012, 32'($random(seed))};
        hit_rd_addr <= {1'b0, hrow({12'h00A, 48'h000011112222}), 2'd1};
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            cfg_i.wr(l2dl_pkg::TBL_EGR_ACT, 13'(i), 64'h0);
            cfg_i.wr(l2dl_pkg::TBL_SRC_ACT, 13'(i), 64'h0);
            if (i < 4) cfg_i.wr(l2dl_pkg::TBL_CAM_MASK, 13'(i), ~64'h0);
        end
        chk("hit bit idle", hit_rd_data, 0);
        for (int i = 0; i < 4; i++) miss(4'd1, 11'h7FF, ex(1,0,0,1,0,11'h7FD));
        idle(2);
        put(12'h00A, 48'h000011112222, 2'd1, 8'h45);
        cfg_i.wr(l2dl_pkg::TBL_AGE, hit_rd_addr, 64'h3);
        look(12'h00A, 48'h000011112222, 4'd1, 11'h7FF, ex(1,0,0,1,0,11'h7FD));
        idle(2);
        cfg_i.wr(l2dl_pkg::TBL_AGE, hit_rd_addr, 64'h7);
        look(12'h00A, 48'h000011112222, 4'd1, 11'h7FF, ex(1,0,1,1,0,11'h020));
        idle(3);
        chk("hit bit set", hit_rd_data, 1);
        put(12'h00B, 48'h00AABB000055, 2'd0, 8'h47);
        cfg_i.wr(l2dl_pkg::TBL_CAM, 13'h0000, {4'h0, 12'h00B, 48'h00AABB000000});
        cfg_i.wr(l2dl_pkg::TBL_CAM_MASK, 13'h0000, 64'h0FFFFFFFFFFFFF00);
        cfg_i.wr(l2dl_pkg::TBL_CAM, 13'h0001, {4'h0, 12'h00B, 48'h00AABB000055});
        for (int i = 0; i < 2; i++) begin
            cfg_i.wr(l2dl_pkg::TBL_CAM_AGE, 13'(i), 64'h3);
            cfg_i.wr(l2dl_pkg::TBL_DEST, 13'(4096 + i), 64'(8'h42 + 6 * i));
        end
        look(12'h00B, 48'h00AABB000055, 4'd1, 11'h7FF, ex(1,0,1,1,0,11'h004));
        idle(2);
        chk("cam hit", res_cam_hit, 1);
        put(12'h00C, 48'h01005E000001, 2'd2, 8'h03);
        cfg_i.wr(l2dl_pkg::TBL_MCAST, 13'h0003, 64'h0F0);
        put(12'h00D, 48'h00000D0D0D0D, 2'd3, 8'h81);
        put(12'h00F, 48'h00000F0F0F0F, 2'd1, 8'h43);
        look(12'h00C, 48'h01005E000001, 4'd4, 11'h0C0, ex(1,0,1,1,0,11'h0C0));
        look(12'h00D, 48'h00000D0D0D0D, 4'd1, 11'h7FF, ex(0,1,1,1,0,0));
        look(12'h00E, l2dl_pkg::BCAST_MAC, 4'd0, 11'h013, ex(1,0,0,1,0,11'h012));
        look(12'h00F, 48'h00000F0F0F0F, 4'd3, 11'h7FF, ex(1,1,1,1,0,0));
        idle(2);
        chk("drop count", lookup_drop_cnt, 1);
        @(posedge sys_clk) req_hairpin_en <= 1'b1;
        look(12'h00F, 48'h00000F0F0F0F, 4'd3, 11'h7FF, ex(1,0,1,1,0,11'h008));
        idle(2);
        req_hairpin_en <= 1'b0;
        req_redir_en <= 1'b1;
        req_redir_port <= 4'd9;
        miss(4'd1, 11'h00F, ex(1,0,0,1,0,11'h200));
        idle(2);
        req_redir_en <= 1'b0;
        action_table_use <= 1'b1;
        fc_v <= 4'h2;
        cfg_i.wr(l2dl_pkg::TBL_RULE, 13'h0001, 64'h2);
        cfg_i.wr(l2dl_pkg::TBL_SRC_ACT, 13'h0000, 64'h01);
        miss(4'd1, 11'h00F, ex(0,1,0,1,0,0));
        sa_v <= {16'h0112, 32'($random(seed))};
        idle(0);
        cfg_i.wr(l2dl_pkg::TBL_SRC_ACT, 13'h0000, 64'h03);
        miss(4'd1, 11'h00F, ex(0,1,0,0,0,0));
        idle(0);
        sa_v <= {16'h0012, 32'($random(seed))};
        miss(4'd1, 11'h00F, ex(0,1,0,1,0,0));
        idle(0);
        cfg_i.wr(l2dl_pkg::TBL_SRC_ACT, 13'h0000, 64'h07);
        miss(4'd1, 11'h00F, ex(0,1,0,0,0,0));
        idle(0);
        cfg_i.wr(l2dl_pkg::TBL_SRC_ACT, 13'h0000, 64'h08);
        miss(4'd1, 11'h00F, ex(1,0,0,1,1,11'h00D));
        idle(0);
        cfg_i.wr(l2dl_pkg::TBL_SRC_ACT, 13'h0000, 64'h61);
        miss(4'd1, 11'h00F, ex(1,0,0,1,0,11'h00D));
        idle(0);
        cfg_i.wr(l2dl_pkg::TBL_SRC_ACT, 13'h0001, 64'h06);
        miss(4'd1, 11'h002, ex(1,1,0,0,0,0));
        idle(4);
        chk("pending results", exp_q.size(), 0);
        conclude();
    end
endmodule : testbench
